// >>> bfx_alu.sv
/*
 * Combinational datapath of the bit and flag instructions.
 * Assumes the sequencer registers every result in the same cycle.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bfx_map.svh"

module bfx_alu
(
  bfx_exec_if.alu ex
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] bfx_put_bit(input logic [7:0] v, input logic [2:0] i,
                                             input logic b);
    logic [7:0] r;
    r = v;
    r[i] = b;
    return r;
  endfunction

  // ****************************************
  // Datapath
  // ****************************************
  always_comb
  begin
    ex.result = ex.operand;
    ex.result_we = 1'b0;
    ex.status_nxt = ex.status;
    if (ex.go)
    begin
      unique case (ex.op)
        bfx_pkg::BFX_OP_STORE_BIT:
          ex.status_nxt = bfx_put_bit(ex.status, `BFX_FLAG_T, ex.operand[ex.idx]);
        bfx_pkg::BFX_OP_LOAD_BIT:
        begin
          ex.result = bfx_put_bit(ex.operand, ex.idx, ex.status[`BFX_FLAG_T]);
          ex.result_we = 1'b1;
        end
        bfx_pkg::BFX_OP_FLAG_SET:
          ex.status_nxt = bfx_put_bit(ex.status, ex.idx, 1'b1);
        bfx_pkg::BFX_OP_FLAG_CLEAR:
          ex.status_nxt = bfx_put_bit(ex.status, ex.idx, 1'b0);
        bfx_pkg::BFX_OP_SWAP:
        begin
          ex.result = {ex.operand[3:0], ex.operand[7:4]};
          ex.result_we = 1'b1;
        end
        default:
        begin
          ex.result = ex.operand;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> bfx_core.sv
/*
 * Bit and flag instruction unit: status flags, eight working registers,
 * a command port that issues one instruction per write, and a register
 * port for inspection. Sleep holds the unit busy for two cycles; the
 * watchdog restart is a one-cycle pulse out.
 * Assumes the master keeps to the plain strobe port with read data one
 * cycle later and issues no command while busy is high.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bfx_map.svh"

module bfx_core
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic busy,
  output logic sleep_req,
  output logic watchdog_restart_op,
  output logic [7:0] status_flags_register
);

  // ****************************************
  // Command decode
  // ****************************************
  bfx_exec_if ex();

  logic cmd_wr;
  logic [3:0] cmd_op_raw;
  logic [2:0] cmd_idx;
  logic [2:0] cmd_reg;
  logic [7:0] wreg_a;
  logic [7:0] wreg_b;

  function automatic logic bfx_is_known_op(input logic [3:0] c);
    return c <= 4'(bfx_pkg::BFX_OP_WDR);
  endfunction

  assign cmd_op_raw = wdata[`BFX_CMD_OP_MSB:`BFX_CMD_OP_LSB];
  assign cmd_idx = wdata[`BFX_CMD_IDX_MSB:`BFX_CMD_IDX_LSB];
  assign cmd_reg = wdata[`BFX_CMD_REG_MSB:`BFX_CMD_REG_LSB];
  assign cmd_wr = wr && (addr == `BFX_ADDR_CMD) && !busy && bfx_is_known_op(cmd_op_raw);

  assign ex.go = cmd_wr;
  assign ex.op = bfx_pkg::bfx_op_t'(cmd_op_raw);
  assign ex.idx = cmd_idx;
  assign ex.operand = wreg_a;
  assign ex.status = status_flags_register;

  bfx_alu u_alu
  (
    .ex(ex)
  );

  // ****************************************
  // Working registers
  // ****************************************
  logic direct_wr;
  logic wf_we;
  logic [2:0] wf_waddr;
  logic [7:0] wf_wdata;

  assign direct_wr = wr && ((addr & `BFX_ADDR_WREG0) == `BFX_ADDR_WREG0);
  always_comb
  begin
    wf_we = 1'b0;
    wf_waddr = cmd_reg;
    wf_wdata = ex.result;
    if (ex.result_we)
    begin
      wf_we = 1'b1;
    end
    else if (direct_wr)
    begin
      wf_we = 1'b1;
      wf_waddr = addr[2:0];
      wf_wdata = wdata[7:0];
    end
  end

  bfx_wreg_file u_wreg
  (
    .clk(clk),
    .rst_n(rst_n),
    .we(wf_we),
    .waddr(wf_waddr),
    .wdata(wf_wdata),
    .raddr_a(cmd_reg),
    .rdata_a(wreg_a),
    .raddr_b(addr[2:0]),
    .rdata_b(wreg_b)
  );

  // ****************************************
  // Status flags
  // ****************************************
  logic [7:0] status_r;
  logic [7:0] status_nxt;

  always_comb
  begin
    status_nxt = status_r;
    if (wr && addr == `BFX_ADDR_STATUS)
    begin
      status_nxt = wdata[7:0];
    end
    else if (cmd_wr)
    begin
      status_nxt = ex.status_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    status_r <= rst_n ? status_nxt : `BFX_STATUS_RST;
  end

  assign status_flags_register = status_r;

  // ****************************************
  // Sleep sequencer
  // ****************************************
  bfx_pkg::bfx_state_t state_r;
  bfx_pkg::bfx_state_t state_nxt;
  logic [1:0] cyc_r;
  logic [1:0] cyc_nxt;
  logic wdr_r;
  logic wdr_nxt;
  logic sleep_r;
  logic sleep_nxt;
  logic [7:0] wdr_count_r;
  logic [7:0] wdr_count_nxt;
  logic [7:0] sleep_count_r;
  logic [7:0] sleep_count_nxt;

  always_comb
  begin
    state_nxt = state_r;
    cyc_nxt = cyc_r;
    wdr_nxt = 1'b0;
    sleep_nxt = 1'b0;
    wdr_count_nxt = wdr_count_r;
    sleep_count_nxt = sleep_count_r;
    unique case (state_r)
      bfx_pkg::BFX_IDLE:
      begin
        if (cmd_wr && ex.op == bfx_pkg::BFX_OP_SLEEP)
        begin
          state_nxt = bfx_pkg::BFX_SLEEP_WAIT;
          cyc_nxt = `BFX_CYC_SLEEP - `BFX_CYC_ONE;
          sleep_count_nxt = sleep_count_r + 8'h01;
        end
        if (cmd_wr && ex.op == bfx_pkg::BFX_OP_WDR)
        begin
          wdr_nxt = 1'b1;
          wdr_count_nxt = wdr_count_r + 8'h01;
        end
      end
      bfx_pkg::BFX_SLEEP_WAIT:
      begin
        cyc_nxt = cyc_r - `BFX_CYC_ONE;
        if (cyc_r == `BFX_CYC_ONE)
        begin
          state_nxt = bfx_pkg::BFX_IDLE;
          sleep_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= bfx_pkg::BFX_IDLE;
      cyc_r <= 2'h0;
      wdr_r <= 1'b0;
      sleep_r <= 1'b0;
      wdr_count_r <= `BFX_ZERO8;
      sleep_count_r <= `BFX_ZERO8;
    end
    else
    begin
      state_r <= state_nxt;
      cyc_r <= cyc_nxt;
      wdr_r <= wdr_nxt;
      sleep_r <= sleep_nxt;
      wdr_count_r <= wdr_count_nxt;
      sleep_count_r <= sleep_count_nxt;
    end
  end

  assign busy = (state_r != bfx_pkg::BFX_IDLE);
  assign watchdog_restart_op = wdr_r;
  assign sleep_req = sleep_r;

  // ****************************************
  // Register read port
  // ****************************************
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (rd)
    begin
      if (addr[3])
      begin
        rdata_nxt = {8'h00, wreg_b};
      end
      else
      begin
        unique case (addr)
          `BFX_ADDR_STATUS: rdata_nxt = {8'h00, status_r};
          `BFX_ADDR_BUSY: rdata_nxt = {15'h0000, busy};
          `BFX_ADDR_WDR_COUNT: rdata_nxt = {8'h00, wdr_count_r};
          `BFX_ADDR_SLEEP_COUNT: rdata_nxt = {8'h00, sleep_count_r};
          default: rdata_nxt = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    rdata_r <= rst_n ? rdata_nxt : 16'h0000;
  end

  assign rdata = rdata_r;

endmodule

`default_nettype wire

// >>> bfx_core_asserts.sv
/*
 * Port assertions of the bit and flag unit.
 * Assumes a bind onto bfx_core and its single clock.
 */
`timescale 1ns/10ps
`default_nettype none

module bfx_core_asserts
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic busy,
  input wire logic sleep_req,
  input wire logic watchdog_restart_op,
  input wire logic [7:0] status_flags_register
);
  // ********************
  // Accepted command decode
  // ********************
  logic cmd;
  logic [3:0] op;
  logic [2:0] idx_q;
  logic wdog_cmd_q;
  assign cmd = wr && addr == 4'h1 && !busy;
  assign op = wdata[3:0];
  always_ff @(posedge clk)
  begin
    idx_q <= wdata[6:4];
    wdog_cmd_q <= cmd && op == 4'h7;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_flag_set: assert property (cmd && op == 4'h3 |=>
    status_flags_register == ($past(status_flags_register) | (8'h01 << idx_q)))
    else $error("flag set wrong");
  a_flag_clear: assert property (cmd && op == 4'h4 |=>
    status_flags_register == ($past(status_flags_register) & ~(8'h01 << idx_q)))
    else $error("flag clear wrong");
  a_store_only_t: assert property (cmd && op == 4'h1 |=>
    ((status_flags_register ^ $past(status_flags_register)) & 8'hbf) == 8'h00)
    else $error("bit store touched other flags");
  a_load_swap_keep: assert property (cmd && (op == 4'h2 || op == 4'h5) |=>
    $stable(status_flags_register)) else $error("flags changed");
  a_sleep_busy: assert property (cmd && op == 4'h6 |=>
    busy [*2] ##1 (!busy && sleep_req)) else $error("sleep timing wrong");
  a_sleep_flags: assert property (cmd && op == 4'h6 |=>
    $stable(status_flags_register)) else $error("sleep changed flags");
  a_sleep_end: assert property (sleep_req |-> $past(busy))
    else $error("sleep pulse without busy");
  a_wdog_pulse: assert property (cmd && op == 4'h7 |=>
    watchdog_restart_op && $stable(status_flags_register)) else $error("restart wrong");
  a_wdog_cause: assert property (watchdog_restart_op |-> wdog_cmd_q)
    else $error("restart pulse without command");
  a_read_idle: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data outside read cycle");
  c_sleep: cover property (cmd && op == 4'h6);
  c_wdog: cover property (watchdog_restart_op);
  c_set: cover property (cmd && op == 4'h3);
endmodule

bind bfx_core bfx_core_asserts bfx_core_asserts_inst
(
  .clk(clk),
  .rst_n(rst_n),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .rd(rd),
  .rdata(rdata),
  .busy(busy),
  .sleep_req(sleep_req),
  .watchdog_restart_op(watchdog_restart_op),
  .status_flags_register(status_flags_register)
);

`default_nettype wire

// >>> bfx_exec_if.sv
/*
 * Interface carrying one decoded instruction from the sequencer to the
 * datapath, and the datapath results back.
 * Assumes a single clock shared by both sides.
 */
`timescale 1ns/10ps
`default_nettype none

interface bfx_exec_if;
  logic go;
  bfx_pkg::bfx_op_t op;
  logic [2:0] idx;
  logic [7:0] operand;
  logic [7:0] status;
  logic [7:0] result;
  logic result_we;
  logic [7:0] status_nxt;

  modport seq
  (
    output go,
    output op,
    output idx,
    output operand,
    output status,
    input result,
    input result_we,
    input status_nxt
  );

  modport alu
  (
    input go,
    input op,
    input idx,
    input operand,
    input status,
    output result,
    output result_we,
    output status_nxt
  );
endinterface

`default_nettype wire

// >>> bfx_map.svh
/*
 * Constants of the bit and flag execution block: status flag positions,
 * command word fields, register port offsets, reset values and cycle counts.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef BFX_MAP_SVH
`define BFX_MAP_SVH

// Status flag bit positions
`define BFX_FLAG_C 3'h0
`define BFX_FLAG_Z 3'h1
`define BFX_FLAG_N 3'h2
`define BFX_FLAG_V 3'h3
`define BFX_FLAG_S 3'h4
`define BFX_FLAG_H 3'h5
`define BFX_FLAG_T 3'h6
`define BFX_FLAG_I 3'h7

// Register port offsets
`define BFX_ADDR_STATUS 4'h0
`define BFX_ADDR_CMD 4'h1
`define BFX_ADDR_BUSY 4'h2
`define BFX_ADDR_WDR_COUNT 4'h3
`define BFX_ADDR_SLEEP_COUNT 4'h4
`define BFX_ADDR_WREG0 4'h8

// Command word fields: [3:0] op, [6:4] bit or flag index, [9:7] register
`define BFX_CMD_OP_LSB 0
`define BFX_CMD_OP_MSB 3
`define BFX_CMD_IDX_LSB 4
`define BFX_CMD_IDX_MSB 6
`define BFX_CMD_REG_LSB 7
`define BFX_CMD_REG_MSB 9

// Reset values
`define BFX_STATUS_RST 8'h00
`define BFX_WREG_RST 8'h00
`define BFX_ZERO8 8'h00

// Cycle counts
`define BFX_CYC_SLEEP 2'h3
`define BFX_CYC_ONE 2'h1

`endif

// >>> bfx_pkg.sv
/*
 * Types of the bit and flag execution block.
 * Assumes bfx_map.svh is on the include path.
 */
`include "bfx_map.svh"

package bfx_pkg;

  typedef enum logic [3:0] {
    BFX_OP_NOP,
    BFX_OP_STORE_BIT,
    BFX_OP_LOAD_BIT,
    BFX_OP_FLAG_SET,
    BFX_OP_FLAG_CLEAR,
    BFX_OP_SWAP,
    BFX_OP_SLEEP,
    BFX_OP_WDR
  } bfx_op_t;

  typedef enum {
    BFX_IDLE,
    BFX_SLEEP_WAIT
  } bfx_state_t;

endpackage

// >>> bfx_wreg_file.sv
/*
 * Eight working registers in flip-flops with one write port and two
 * read ports, one for the datapath and one for the register port.
 * Assumes synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bfx_map.svh"

module bfx_wreg_file
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] raddr_a,
  output logic [7:0] rdata_a,
  input wire logic [2:0] raddr_b,
  output logic [7:0] rdata_b
);

  logic [7:0] mem_r [8];
  logic [7:0] mem_nxt [8];

  always_comb
  begin
    for (int k = 0; k < 8; k++)
    begin
      mem_nxt[k] = mem_r[k];
    end
    if (we)
    begin
      mem_nxt[waddr] = wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    for (int k = 0; k < 8; k++)
    begin
      mem_r[k] <= rst_n ? mem_nxt[k] : `BFX_WREG_RST;
    end
  end

  assign rdata_a = mem_r[raddr_a];
  assign rdata_b = mem_r[raddr_b];

endmodule

`default_nettype wire

// >>> cpu_bit_flag_instructions_bench.sv
/*
 * Self-checking bench of the bit and flag unit.
 * Assumes bfx_core and its package are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module cpu_bit_flag_instructions_bench;
  typedef struct {logic [15:0] v; string nm;} bfx_note_t;
  logic clk, rst_n, wr, rd, busy, sleep_req, wdog;
  logic rd_q = 1'h0;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  logic [15:0] sleeps = 16'h0000;
  logic [15:0] wdogs = 16'h0000;
  logic [7:0] st, flags, rv;
  logic [2:0] b;
  bfx_note_t notes[$];
  int fail_count, tests_run;
  integer seed;
  bfx_core bfx_core_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .busy(busy), .sleep_req(sleep_req),
    .watchdog_restart_op(wdog), .status_flags_register(flags));
  // ********************
  // Tasks
  // ********************
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task rd_exp(input logic [3:0] a, input logic [15:0] e, input string nm);
    notes.push_back('{e, nm});
    bus(1'h0, 1'h1, a, 16'h0000);
  endtask
  task cmd(input logic [3:0] op, input logic [2:0] idx, input logic [2:0] r);
    bus(1'h1, 1'h0, 4'h1, {6'h00, r, idx, op});
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ********************
  // Clock, monitor, timeout
  // ********************
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    bfx_note_t got;
    if (rd_q)
    begin
      got = notes.pop_front();
      check(got.nm, rdata, got.v);
    end
    rd_q <= rd;
    if (sleep_req === 1'h1)
      sleeps <= sleeps + 16'h0001;
    if (wdog === 1'h1)
      wdogs <= wdogs + 16'h0001;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_sim();
  end
  // ********************
  // Main sequence
  // ********************
  initial
  begin
    seed = 32'h1d85418f;
    {rst_n, wr, rd, addr, wdata} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd_exp(4'h0, 16'h0000, "status reset");
    rd_exp(4'h8, 16'h0000, "reg reset");
    rd_exp(4'h2, 16'h0000, "busy idle");
    rd_exp(4'h5, 16'h0000, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      st = $random(seed);
      bus(1'h1, 1'h0, 4'h0, {8'h00, st});
      cmd(4'h3, i[2:0], 3'h0);
      st[i] = 1'h1;
      rd_exp(4'h0, {8'h00, st}, "flag set");
      cmd(4'h4, i[2:0], 3'h0);
      st[i] = 1'h0;
      rd_exp(4'h0, {8'h00, st}, "flag clear");
    end
    $display("test flags done");
    for (int i = 0; i < 8; i++)
    begin
      rv = $random(seed);
      b = ~i[2:0];
      bus(1'h1, 1'h0, {1'h1, i[2:0]}, {8'h00, rv});
      cmd(4'h1, b, i[2:0]);
      st[6] = rv[b];
      rd_exp(4'h0, {8'h00, st}, "bit store");
      st[6] = ~st[6];
      bus(1'h1, 1'h0, 4'h0, {8'h00, st});
      cmd(4'h2, b, i[2:0]);
      rv[b] = st[6];
      rd_exp({1'h1, i[2:0]}, {8'h00, rv}, "bit load");
      cmd(4'h5, 3'h0, i[2:0]);
      rv = {rv[3:0], rv[7:4]};
      rd_exp({1'h1, i[2:0]}, {8'h00, rv}, "swap");
      rd_exp(4'h0, {8'h00, st}, "flags kept");
      check("flag port", {8'h00, flags}, {8'h00, st});
    end
    $display("test bits done");
    st = $random(seed);
    st[0] = 1'h0;
    bus(1'h1, 1'h0, 4'h0, {8'h00, st});
    cmd(4'h6, 3'h0, 3'h0);
    rd_exp(4'h2, 16'h0001, "busy high");
    check("busy port", {15'h0000, busy}, 16'h0001);
    cmd(4'h3, 3'h0, 3'h0);
    rd_exp(4'h2, 16'h0000, "busy low");
    rd_exp(4'h0, {8'h00, st}, "sleep flags");
    cmd(4'h7, 3'h0, 3'h0);
    cmd(4'h8, 3'h0, 3'h0);
    cmd(4'h0, 3'h5, 3'h0);
    rd_exp(4'h0, {8'h00, st}, "restart flags");
    rd_exp(4'h3, 16'h0001, "restart count");
    rd_exp(4'h4, 16'h0001, "sleep count");
    bus(1'h0, 1'h0, 4'h0, 16'h0000);
    bus(1'h0, 1'h0, 4'h0, 16'h0000);
    check("sleep pulses", sleeps, 16'h0001);
    check("restart pulses", wdogs, 16'h0001);
    $display("test sleep and restart done");
    end_sim();
  end
endmodule

`default_nettype wire
